// ### src/rcto_core.v
/*
  Reset-cause flags, processor status time-out/power-down flags and
  start-up time-out sequencer, with an APB slave for the flags.
  Assumes i_clk is the oscillator clock, watchdog and interrupt wake
  events come as one-cycle pulses from logic on i_clk, and the reset pin
  and brown-out detector are asynchronous levels.
*/
//
// Contract
// RL1 - A reset-cause register holds two flags naming the latest reset.
// RL2 - Bit 0 is active-low brown-out flag, cleared by every brown-out reset.
// RL3 - Software sets brown-out flag after power-on, then checks it later.
// RL4 - With brown-out detection off the brown-out flag means nothing.
// RL5 - Bit 1 is active-low power-on flag, cleared only by power-on reset.
// RL6 - Software sets the power-on flag after every power-on reset.
// RL7 - Start-up delay per oscillator mode: 72 ms and/or 1024 periods.
// RL8 - Power-on sets time-out and power-down status flags (bits 4, 3).
// RL9 - Each reset or wake event sets time-out/power-down flags per table.
// RL10 - Resets restart at 000h; wake-ups continue after the sleep.
// RL11 - Interrupt wake with global enable set branches to 0004h.
// RL12 - Unimplemented bits read as zero.
// RL13 - Watchdog wake-up does not reset registers.
// RL14 - Brown-out detection enabled forces the 72 ms delay on.
`timescale 1ns/10ps
`include "rcto_defs.vh"

module rcto_core #(
  parameter PWRT_CYCLES = `RCTO_PWRT_CYCLES,
  parameter OST_CYCLES = `RCTO_OST_TOSC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_arst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // Configuration
  input wire [1:0] i_osc_mode,
  input wire i_powerup_delay_enable_n,
  input wire i_brownout_detect_enable,
  // Reset and wake sources
  input wire i_master_clear_pin_n,
  input wire i_brownout_n,
  input wire i_watchdog_evt,
  input wire i_irq_wake_evt,
  input wire i_sleep_active,
  input wire i_global_irq_enable,
  // Processor control
  output reg o_cpu_hold,
  output reg o_periph_reset,
  output reg o_restart,
  output reg o_restart_resume,
  output reg [12:0] o_restart_addr
);

  // ==========================================================
  // Sequencer states
  localparam [2:0] S_START = 3'h0;
  localparam [2:0] S_PWRT = 3'h1;
  localparam [2:0] S_OST = 3'h2;
  localparam [2:0] S_PIN = 3'h3;
  localparam [2:0] S_RUN = 3'h4;
  localparam [2:0] S_GO = 3'h5;

  // ==========================================================
  // Pin synchronisers
  reg [1:0] pin_sync_q;
  reg [1:0] bo_sync_q;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_sync_q <= 2'h3;
      bo_sync_q <= 2'h3;
    end else begin
      pin_sync_q <= {pin_sync_q[0], i_master_clear_pin_n};
      bo_sync_q <= {bo_sync_q[0], i_brownout_n};
    end
  end
  wire pin_low = ~pin_sync_q[1];
  // Detector output is ignored while detection is off
  wire bo_low = ~bo_sync_q[1] & i_brownout_detect_enable; // RL4
  reg bo_low_q;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      bo_low_q <= 1'b0;
    else
      bo_low_q <= bo_low;
  end
  wire bo_evt = bo_low & ~bo_low_q;

  // ==========================================================
  // Sequencer
  wire crystal = (i_osc_mode != `RCTO_OSC_RC);
  // Delay forced on while brown-out detection is enabled
  wire pwrt_on = ~i_powerup_delay_enable_n | i_brownout_detect_enable; // RL14
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [19:0] cnt_q;
  reg [19:0] cnt_d;
  reg resume_q;
  reg resume_d;
  reg [12:0] addr_q;
  reg [12:0] addr_d;
  reg to_n_q;
  reg to_n_d;
  reg slp_flag_n_q;
  reg slp_flag_n_d;
  reg bo_flag_n_q;
  reg bo_flag_n_d;
  reg por_n_q;
  reg por_n_d;
  reg hold_d;
  reg prst_d;
  reg go_d;
  reg [1:0] cause_q;
  reg [1:0] cause_d;

  // Software write strobes; hardware clears take priority over them
  wire wr = i_psel & i_penable & i_pwrite;
  wire wr_cause = wr & (i_paddr == `RCTO_OFS_CAUSE);

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    resume_d = resume_q;
    addr_d = addr_q;
    to_n_d = to_n_q;
    slp_flag_n_d = slp_flag_n_q;
    bo_flag_n_d = bo_flag_n_q;
    por_n_d = por_n_q;
    cause_d = cause_q;
    go_d = 1'b0;
    if (wr_cause) begin
      bo_flag_n_d = i_pwdata[`RCTO_BIT_BROWNOUT]; // RL3
      por_n_d = i_pwdata[`RCTO_BIT_POWERON]; // RL6
    end
    case (state_q)
      S_START: begin
        // Power-on: the flags already hold their power-on values
        resume_d = 1'b0;
        addr_d = `RCTO_ADDR_RESET; // RL10
        cause_d = 2'h0;
        cnt_d = 20'h00000;
        if (pwrt_on)
          state_d = S_PWRT; // RL7
        else if (crystal)
          state_d = S_OST; // RL7
        else
          state_d = S_GO;
      end
      S_PWRT: begin
        if (cnt_q == PWRT_CYCLES[19:0] - 20'h00001) begin
          cnt_d = 20'h00000;
          state_d = crystal ? S_OST : S_GO; // RL7
        end else
          cnt_d = cnt_q + 20'h00001;
      end
      S_OST: begin
        if (cnt_q == OST_CYCLES[19:0] - 20'h00001) begin
          cnt_d = 20'h00000;
          state_d = S_GO;
        end else
          cnt_d = cnt_q + 20'h00001;
      end
      S_PIN: begin
        // Execution starts as soon as the pin is released
        if (!pin_low)
          state_d = S_GO;
      end
      S_GO: begin
        go_d = 1'b1;
        state_d = S_RUN;
      end
      S_RUN: begin
        if (i_watchdog_evt) begin
          to_n_d = 1'b0; // RL9
          slp_flag_n_d = ~i_sleep_active; // RL9
          cause_d = i_sleep_active ? 2'h2 : 2'h1;
          resume_d = i_sleep_active; // RL13
          addr_d = `RCTO_ADDR_RESET; // RL10
          state_d = (i_sleep_active && crystal) ? S_OST : S_GO; // RL7
        end else if (i_irq_wake_evt && i_sleep_active) begin
          to_n_d = 1'b1; // RL9
          slp_flag_n_d = 1'b0; // RL9
          cause_d = 2'h3;
          resume_d = ~i_global_irq_enable; // RL10
          addr_d = i_global_irq_enable ? `RCTO_ADDR_IRQ : `RCTO_ADDR_RESET; // RL11
          state_d = crystal ? S_OST : S_GO; // RL7
        end
      end
      default: state_d = S_START;
    endcase
    // Pin reset outranks watchdog and interrupt wake in all but the time-out flag clear and power-down flag set of an awake watchdog
    if (pin_low && state_q != S_PIN && state_q != S_PWRT) begin
      if (i_sleep_active) begin
        to_n_d = 1'b1; // RL9
        slp_flag_n_d = 1'b0; // RL9
      end
      resume_d = 1'b0;
      addr_d = `RCTO_ADDR_RESET; // RL10
      cause_d = 2'h1;
      cnt_d = 20'h00000;
      go_d = 1'b0;
      state_d = S_PIN;
    end
    // Brown-out outranks all; a new dip restarts the delay
    if (bo_low) begin
      bo_flag_n_d = 1'b0; // RL2
      to_n_d = 1'b1; // RL9
      slp_flag_n_d = 1'b1; // RL9
      resume_d = 1'b0;
      addr_d = `RCTO_ADDR_RESET; // RL10
      cause_d = 2'h1;
      cnt_d = 20'h00000;
      go_d = 1'b0;
      state_d = S_PWRT; // RL7
    end
    hold_d = (state_d != S_RUN);
    // Wake-ups leave registers untouched
    prst_d = hold_d & ~resume_d & (addr_d == `RCTO_ADDR_RESET) & (cause_d != 2'h3); // RL13
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= S_START;
      cnt_q <= 20'h00000;
      resume_q <= 1'b0;
      addr_q <= `RCTO_ADDR_RESET;
      cause_q <= 2'h0;
      to_n_q <= `RCTO_RST_TIMEOUT; // RL8
      slp_flag_n_q <= `RCTO_RST_POWERDOWN; // RL8
      bo_flag_n_q <= `RCTO_RST_BROWNOUT; // RL2
      por_n_q <= `RCTO_RST_POWERON; // RL5
      o_cpu_hold <= 1'b1;
      o_periph_reset <= 1'b1;
      o_restart <= 1'b0;
      o_restart_resume <= 1'b0;
      o_restart_addr <= `RCTO_ADDR_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      resume_q <= resume_d;
      addr_q <= addr_d;
      cause_q <= cause_d;
      to_n_q <= to_n_d;
      slp_flag_n_q <= slp_flag_n_d;
      bo_flag_n_q <= bo_flag_n_d;
      por_n_q <= por_n_d;
      o_cpu_hold <= hold_d;
      o_periph_reset <= prst_d;
      o_restart <= go_d;
      if (go_d) begin
        o_restart_resume <= resume_q; // RL10
        o_restart_addr <= addr_q; // RL11
      end
    end
  end

  // ==========================================================
  // APB read path: data captured in the setup cycle, zero wait states
  assign o_pready = 1'b1;
  reg [31:0] rdata;
  reg rerr;
  always @* begin
    rdata = 32'h00000000; // RL12
    rerr = 1'b0;
    case (i_paddr)
      `RCTO_OFS_CAUSE: begin
        rdata[`RCTO_BIT_BROWNOUT] = bo_flag_n_q; // RL1
        rdata[`RCTO_BIT_POWERON] = por_n_q; // RL1
      end
      `RCTO_OFS_STATUS: begin
        rdata[`RCTO_BIT_TIMEOUT] = to_n_q; // RL9
        rdata[`RCTO_BIT_POWERDOWN] = slp_flag_n_q; // RL9
      end
      `RCTO_OFS_SEQ: begin
        rdata[2:0] = state_q;
        rdata[4:3] = cause_q;
        rdata[5] = o_cpu_hold;
      end
      default: rerr = 1'b1;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_prdata <= i_pwrite ? 32'h00000000 : rdata;
      o_pslverr <= rerr;
    end else if (!i_psel) begin
      o_pslverr <= 1'b0;
    end
  end

endmodule // rcto_core

// ### src/rcto_defs.vh
/*
  Constants of the reset-cause and start-up time-out block: register
  offsets, field positions, reset values, encodings and timing counts.
  Assumes a 10 MHz clock that is also the oscillator clock.
*/
`ifndef RCTO_DEFS_VH
`define RCTO_DEFS_VH

// ==========================================================
// Register offsets (byte addresses)
`define RCTO_OFS_CAUSE 12'h000
`define RCTO_OFS_STATUS 12'h004
`define RCTO_OFS_SEQ 12'h008

// ==========================================================
// Field positions
`define RCTO_BIT_BROWNOUT 0
`define RCTO_BIT_POWERON 1
`define RCTO_BIT_POWERDOWN 3
`define RCTO_BIT_TIMEOUT 4

// ==========================================================
// Reset values of the flags after power-on
`define RCTO_RST_BROWNOUT 1'b0
`define RCTO_RST_POWERON 1'b0
`define RCTO_RST_TIMEOUT 1'b1
`define RCTO_RST_POWERDOWN 1'b1

// ==========================================================
// Oscillator modes
`define RCTO_OSC_LOWPOWER 2'h0
`define RCTO_OSC_STANDARD 2'h1
`define RCTO_OSC_FAST 2'h2
`define RCTO_OSC_RC 2'h3

// ==========================================================
// Restart addresses
`define RCTO_ADDR_RESET 13'h0000
`define RCTO_ADDR_IRQ 13'h0004

// ==========================================================
// Timing
`define RCTO_CLK_KHZ 10000
`define RCTO_PWRT_MS 72
`define RCTO_PWRT_CYCLES (`RCTO_PWRT_MS * `RCTO_CLK_KHZ)
`define RCTO_OST_TOSC 1024

`endif

// ### tb/rcto_core_properties.sv
/*
  Port checker of the reset-cause and start-up time-out block.
  Assumes it is bound to every rcto_core instance.
*/
`timescale 1ns/10ps
module rcto_core_properties #(
  parameter PWRT_CYCLES = 50,
  parameter OST_CYCLES = 16
) (
  // Clock, reset and APB
  input wire i_clk, input wire i_arst_n,
  input wire i_psel, input wire i_penable, input wire i_pwrite,
  input wire [11:0] i_paddr, input wire [31:0] i_pwdata,
  input wire o_pready, input wire [31:0] o_prdata, input wire o_pslverr,
  // Configuration and sources
  input wire [1:0] i_osc_mode, input wire i_powerup_delay_enable_n,
  input wire i_brownout_detect_enable, input wire i_master_clear_pin_n,
  input wire i_brownout_n, input wire i_watchdog_evt, input wire i_irq_wake_evt,
  input wire i_sleep_active, input wire i_global_irq_enable,
  // Processor control
  input wire o_cpu_hold, input wire o_periph_reset, input wire o_restart,
  input wire o_restart_resume, input wire [12:0] o_restart_addr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // Restart
  chk_restart_one_cycle: assert property (o_restart |=> !o_restart)
    else $error("restart pulse longer than one cycle");
  chk_restart_ends_hold: assert property (o_restart |-> !o_cpu_hold && $past(o_cpu_hold))
    else $error("restart without a preceding hold");
  chk_wake_keeps_regs: assert property (o_restart && o_restart_resume |-> !o_periph_reset)
    else $error("peripheral reset on a wake-up");
  chk_reset_zero_addr: assert property (
    o_restart && !o_restart_resume && !i_global_irq_enable |-> o_restart_addr == 13'h0000)
    else $error("reset restart not at address zero");
  chk_irq_vector_enable: assert property (
    o_restart && o_restart_addr == 13'h0004 |-> i_global_irq_enable)
    else $error("vector taken without global enable");
  // ==========================================================
  // Events
  chk_awake_watchdog_seq: assert property (
    i_watchdog_evt && !o_cpu_hold && !i_sleep_active |=> o_cpu_hold ##1 o_restart)
    else $error("watchdog reset sequence wrong");
  chk_sleep_wake_ost: assert property (
    (i_watchdog_evt || i_irq_wake_evt) && !o_cpu_hold
    && i_sleep_active && i_osc_mode != 2'h3 |=> o_cpu_hold [*8])
    else $error("crystal wake-up without start-up delay");
  // ==========================================================
  // Register bus
  chk_unused_bits_zero: assert property (o_prdata[31:6] == 26'h0)
    else $error("unimplemented read bits not zero");
  chk_unmapped_error: assert property (
    i_psel && i_penable && !(i_paddr inside {12'h000, 12'h004, 12'h008}) |-> o_pslverr)
    else $error("no error on unmapped address");
  cover property (o_restart && o_restart_resume);
  cover property (o_restart && o_restart_addr == 13'h0004);
  cover property (i_psel && i_penable && o_pslverr);
endmodule // rcto_core_properties

bind rcto_core rcto_core_properties #(.PWRT_CYCLES(PWRT_CYCLES), .OST_CYCLES(OST_CYCLES))
  chk_u (.*);

// ### tb/tb_top.sv
/*
  Bench of the reset-cause block: APB tasks and reset and wake scenarios.
  Assumes shortened power-up and oscillator start-up counts.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int PW = 50;
  localparam int OST = 16;
  reg i_clk = 0, i_arst_n = 0, psel = 0, pen = 0, pwr = 0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [1:0] osc = 2'h1;
  reg dly_en_n = 0, bod = 0, pin_n = 1, bo_n = 1, wd_evt = 0, irq = 0, slp = 0, global_irq_enable = 0;
  wire pready, pslverr, hold, prst, rst, res;
  wire [31:0] prdata;
  wire [12:0] addr;
  int failures = 0, n_checks = 0, n_cyc;
  rcto_core #(.PWRT_CYCLES(PW), .OST_CYCLES(OST)) dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_osc_mode(osc),
    .i_powerup_delay_enable_n(dly_en_n), .i_brownout_detect_enable(bod),
    .i_master_clear_pin_n(pin_n), .i_brownout_n(bo_n), .i_watchdog_evt(wd_evt),
    .i_irq_wake_evt(irq), .i_sleep_active(slp), .i_global_irq_enable(global_irq_enable),
    .o_cpu_hold(hold), .o_periph_reset(prst), .o_restart(rst),
    .o_restart_resume(res), .o_restart_addr(addr));
  initial forever #50 i_clk = ~i_clk;
  // ==========================================================
  // Tasks
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge i_clk);
    psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    pen <= 1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rd = prdata; err = pslverr;
    psel <= 0; pen <= 0;
  endtask
  task rdchk(input [11:0] a, input [31:0] exp);
    apb(0, a, 32'h0);
    chk("read data", rd, exp);
  endtask
  // Waits for the restart pulse; a negative expectation is not checked
  task wait_rs(input int en, input int ea, input int er);
    reg pr;
    n_cyc = 0; pr = 0;
    while (rst !== 1'b1 && n_cyc < 5000) begin
      @(posedge i_clk);
      wd_evt <= 0; irq <= 0;
      #1 n_cyc = n_cyc + 1;
      pr = pr | (prst !== 1'b0);
    end
    chk("restart", rst, 1);
    if (en >= 0) chk("hold cycles", n_cyc, en);
    if (ea >= 0) chk("restart addr", addr, ea);
    if (er >= 0) chk("resume", res, er);
    if (er == 1) chk("periph reset", pr, 0);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1;
    wait_rs(-1, 0, 0);
    rdchk(12'h000, 32'h0);
    rdchk(12'h004, 32'h18);
    apb(1, 12'h000, 32'hffff_ffff);
    rdchk(12'h000, 32'h3);
    @(posedge i_clk) wd_evt <= 1;
    wait_rs(2, 0, 0);
    rdchk(12'h004, 32'h08);
    @(posedge i_clk) pin_n <= 0;
    repeat (5) @(posedge i_clk);
    pin_n <= 1;
    wait_rs(-1, 0, 0);
    rdchk(12'h004, 32'h08);
    rdchk(12'h000, 32'h3);
    @(posedge i_clk) begin slp <= 1; wd_evt <= 1; end
    wait_rs(OST + 2, -1, 1);
    rdchk(12'h004, 32'h00);
    @(posedge i_clk) begin global_irq_enable <= 1; irq <= 1; end
    wait_rs(OST + 2, 4, -1);
    rdchk(12'h004, 32'h10);
    @(posedge i_clk) begin osc <= 2'h3; global_irq_enable <= 0; wd_evt <= 1; end
    wait_rs(2, -1, 1);
    @(posedge i_clk) begin slp <= 0; osc <= 2'h1; bod <= 1; dly_en_n <= 1; bo_n <= 0; end
    repeat (5) @(posedge i_clk);
    bo_n <= 1;
    wait_rs(-1, 0, 0);
    chk("forced delay", n_cyc > PW + OST, 1);
    rdchk(12'h000, 32'h2);
    rdchk(12'h004, 32'h18);
    apb(1, 12'h004, 32'h0);
    rdchk(12'h004, 32'h18);
    apb(0, 12'h00c, 32'h0);
    chk("pslverr", err, 1);
    chk("unmapped data", rd, 0);
    end_sim;
  end
  initial begin
    #1_000_000;
    failures++;
    end_sim;
  end
endmodule // tb_top
